// *** verilog/brsq_top.sv ***
// Brownout reset sequencer: holds internal reset, times settling, idle countdown.
// Assumes supply detector levels arrive asynchronously; clock is doubled MCLK.
//
// Notes on behaviour
// RL1: Above one volt, logic holds internal reset.
// RL2: Rising past 1.8V starts settling delay.
// RL3: Brownout presets idle timer 00F0 to 00FF.
// RL4: Countdown needs threshold and expired delay.
// RL5: Falling below threshold asserts reset immediately.
// RL6: Dip below 1.8V restarts settling delay.
// RL7: Shallow dip skips delay, countdown on return.
// RL8: Reset held until idle timer underflows.
// RL9: Internal reset acts as external reset.
// RL10: No further resets while above threshold.
// RL11: Disabled: no internal resets, external reset used.
// RL12: Data and RAM contents undefined after reset.
// RL13: Core clock is twice selected oscillator.
// RL14: Instruction cycle is ten core clocks.
// RL15: Low-speed 32 kHz selection gives 64 kHz.
// RL16: Supply indications synchronised; delay parameterised count.
// RL17: Reset asserts asynchronously, releases synchronously.
`timescale 1ns/10ps
`include "brsq_defines.svh"
module brsq_top #(
  parameter int unsigned SETTLE_CYC = `BRSQ_SETTLE_CYC,
  parameter int unsigned TC_DIV     = `BRSQ_MCLK_PER_TC,
  parameter logic [15:0] IDLE_PRE   = `BRSQ_IDLE_PRESET
) (
  // Clock, reset, enable
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST_B,
  input  wire logic        I_CE,
  // Supply detectors and options
  input  wire logic        I_ABOVE_TRIG,
  input  wire logic        I_ABOVE_BOR,
  input  wire logic        I_BOR_ENABLE,
  input  wire logic        I_EXT_RESET_B,
  input  wire logic        I_LOW_SPEED_SEL,
  // Outputs
  output logic             O_CORE_RESET_B,
  output logic             O_IDLE_LOAD,
  output logic [15:0]      O_IDLE_TIMER,
  output logic [2:0]       O_STATUS,
  output logic [1:0]       O_CLK_MULT,
  output logic             O_LOW_SPEED
);
  brsq_pkg::brsq_state_t state_reg;
  logic              trig_s;
  logic              bor_s;
  logic              ext_b_s;
  logic              en_s;
  logic [22:0]       settle_reg;
  logic [3:0]        tc_reg;
  logic              tc_tick;
  logic              underflow;
  logic              run_reg;
  logic              bor_async_b;
  logic              hold_b;
  logic              rel_meta_reg;

  // Synchronise detector levels, external reset and option
  brsq_sync2 #(.RESET_VAL(1'b0)) u_trig (.i_clk(I_SYS_CLK), .i_rst_b(I_RST_B), .i_ce(I_CE),
    .i_d(I_ABOVE_TRIG), .o_q(trig_s)); // RL16
  brsq_sync2 #(.RESET_VAL(1'b0)) u_bor (.i_clk(I_SYS_CLK), .i_rst_b(I_RST_B), .i_ce(I_CE),
    .i_d(I_ABOVE_BOR), .o_q(bor_s)); // RL16
  brsq_sync2 #(.RESET_VAL(1'b0)) u_ext (.i_clk(I_SYS_CLK), .i_rst_b(I_RST_B), .i_ce(I_CE),
    .i_d(I_EXT_RESET_B), .o_q(ext_b_s));
  brsq_sync2 #(.RESET_VAL(1'b0)) u_en (.i_clk(I_SYS_CLK), .i_rst_b(I_RST_B), .i_ce(I_CE),
    .i_d(I_BOR_ENABLE), .o_q(en_s));

  // Instruction-cycle prescaler
  assign tc_tick   = (tc_reg == 4'(TC_DIV - 1)); // RL14
  assign underflow = (state_reg == brsq_pkg::BRSQ_COUNT) && tc_tick
                     && (O_IDLE_TIMER == 16'h0000);

  // Sequencer state
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      state_reg <= brsq_pkg::BRSQ_UNPOWERED; // RL1
    else if (I_CE)
    begin
      if (!trig_s)
        state_reg <= brsq_pkg::BRSQ_UNPOWERED; // RL6
      else if (state_reg == brsq_pkg::BRSQ_UNPOWERED)
        state_reg <= brsq_pkg::BRSQ_SETTLE; // RL2
      else if (state_reg == brsq_pkg::BRSQ_SETTLE)
      begin
        if (settle_reg == 23'(SETTLE_CYC - 1))
          state_reg <= bor_s ? brsq_pkg::BRSQ_COUNT : brsq_pkg::BRSQ_WAIT_BOR; // RL4
      end
      else if (!bor_s)
        state_reg <= brsq_pkg::BRSQ_WAIT_BOR; // RL7
      else if (state_reg == brsq_pkg::BRSQ_WAIT_BOR)
        state_reg <= brsq_pkg::BRSQ_COUNT; // RL4
    end
  end

  // Settling delay counter
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      settle_reg <= 23'h000000;
    else if (I_CE)
    begin
      if (state_reg != brsq_pkg::BRSQ_SETTLE)
        settle_reg <= 23'h000000;
      else
        settle_reg <= settle_reg + 23'h000001; // RL16
    end
  end

  // Instruction-cycle counter runs only while counting down
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      tc_reg <= 4'h0;
    else if (I_CE)
    begin
      if (state_reg != brsq_pkg::BRSQ_COUNT || tc_tick)
        tc_reg <= 4'h0;
      else
        tc_reg <= tc_reg + 4'h1;
    end
  end

  // Idle timer preset and countdown
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      O_IDLE_TIMER <= IDLE_PRE;
      O_IDLE_LOAD  <= 1'b1;
    end
    else if (I_CE)
    begin
      O_IDLE_LOAD <= en_s && (state_reg != brsq_pkg::BRSQ_COUNT) && !run_reg;
      if (en_s && (state_reg != brsq_pkg::BRSQ_COUNT) && !run_reg)
        O_IDLE_TIMER <= IDLE_PRE; // RL3
      else if (state_reg == brsq_pkg::BRSQ_COUNT && tc_tick && !underflow)
        O_IDLE_TIMER <= O_IDLE_TIMER - 16'h0001;
    end
  end

  // Run flag set at underflow, dropped by any brownout
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      run_reg <= 1'b0;
    else if (I_CE)
    begin
      if (!bor_s || !trig_s)
        run_reg <= 1'b0; // RL5
      else if (underflow)
        run_reg <= 1'b1; // RL8 RL10
    end
  end

  // Raw brownout condition asserts reset without the clock
  assign bor_async_b = I_RST_B && (!en_s || (I_ABOVE_BOR && I_ABOVE_TRIG)); // RL17
  assign hold_b      = en_s ? run_reg : 1'b1; // RL11

  // Core reset: async assert, two-flop sync release, ANDed with external
  always_ff @(posedge I_SYS_CLK or negedge bor_async_b)
  begin
    if (!bor_async_b)
    begin
      rel_meta_reg   <= 1'b0; // RL5
      O_CORE_RESET_B <= 1'b0; // RL9
    end
    else if (I_CE)
    begin
      rel_meta_reg   <= hold_b && ext_b_s; // RL9
      O_CORE_RESET_B <= rel_meta_reg; // RL17 RL12
    end
  end

  // Status and clock doubler record
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      O_STATUS    <= brsq_pkg::BRSQ_ST_OFF;
      O_CLK_MULT  <= 2'h2;
      O_LOW_SPEED <= 1'b0;
    end
    else if (I_CE)
    begin
      O_CLK_MULT  <= 2'(`BRSQ_DOUBLER_FACTOR); // RL13
      O_LOW_SPEED <= I_LOW_SPEED_SEL; // RL15
      if (run_reg)
        O_STATUS <= brsq_pkg::BRSQ_ST_RUN;
      else
        case (state_reg)
          brsq_pkg::BRSQ_UNPOWERED: O_STATUS <= brsq_pkg::BRSQ_ST_OFF;
          brsq_pkg::BRSQ_SETTLE:    O_STATUS <= brsq_pkg::BRSQ_ST_SETTLE;
          brsq_pkg::BRSQ_WAIT_BOR:  O_STATUS <= brsq_pkg::BRSQ_ST_WAIT;
          default:                  O_STATUS <= brsq_pkg::BRSQ_ST_COUNT;
        endcase
    end
  end

  // Assertions
  sequence s_dip;
    I_CE && !bor_s;
  endsequence
  a_dip_drops_run: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B) // RL5
    s_dip |=> !run_reg) else $error("run not dropped on brownout");
  a_preset_value: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B) // RL3
    O_IDLE_LOAD |-> O_IDLE_TIMER >= `BRSQ_IDLE_PRESET_MIN) else $error("bad preset");
  a_count_needs_bor: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B) // RL4
    I_CE && state_reg != brsq_pkg::BRSQ_COUNT && !bor_s
    |=> state_reg != brsq_pkg::BRSQ_COUNT) else $error("count below threshold");
  a_low_trig_reset: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B) // RL6
    I_CE && !trig_s |=> state_reg == brsq_pkg::BRSQ_UNPOWERED) else $error("no restart");
  a_run_release: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B) // RL8
    I_CE && en_s && !run_reg |=> !O_CORE_RESET_B) else $error("early release");
  a_prescale_ten: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B) // RL14
    tc_reg < 4'(TC_DIV)) else $error("prescaler overrun");
  a_disabled_free: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B) // RL11
    I_CE && !en_s && ext_b_s ##1 I_CE && !en_s && ext_b_s ##1 I_CE && !en_s && ext_b_s
    |-> O_CORE_RESET_B) else $error("reset while disabled");
  a_settle_start: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B) // RL2
    I_CE && trig_s && state_reg == brsq_pkg::BRSQ_UNPOWERED
    |=> state_reg == brsq_pkg::BRSQ_SETTLE) else $error("settle not started");
  a_stays_run: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B) // RL10
    I_CE && run_reg && bor_s && trig_s |=> run_reg) else $error("spurious reset");
endmodule // brsq_top

// *** verilog/brsq_defines.svh ***
// Constants for the brownout reset sequencer: timing and preset values.
// Assumes a core clock of 20 MHz (doubled 10 MHz oscillator).
`ifndef BRSQ_DEFINES_SVH
`define BRSQ_DEFINES_SVH
`define BRSQ_CLK_HZ          20000000
`define BRSQ_SETTLE_US       3000
`define BRSQ_SETTLE_CYC      ((`BRSQ_CLK_HZ / 1000000) * `BRSQ_SETTLE_US)
`define BRSQ_MCLK_PER_TC     10
`define BRSQ_IDLE_PRESET     16'h00FF
`define BRSQ_IDLE_PRESET_MIN 16'h00F0
`define BRSQ_DOUBLER_FACTOR  2
`endif

// *** verilog/brsq_pkg.sv ***
// Types for the brownout reset sequencer.
// Assumes brsq_defines.svh supplies the numeric constants.
package brsq_pkg;
  typedef enum logic [1:0] {BRSQ_UNPOWERED, BRSQ_SETTLE, BRSQ_WAIT_BOR, BRSQ_COUNT} brsq_state_t;
  typedef enum logic [2:0] {BRSQ_ST_OFF, BRSQ_ST_SETTLE, BRSQ_ST_WAIT, BRSQ_ST_COUNT,
                            BRSQ_ST_RUN} brsq_status_t;
endpackage

// *** verilog/brsq_sync2.sv ***
// Two-flop synchroniser for asynchronous level inputs.
// Assumes a single clock domain and an active-low asynchronous reset.
`timescale 1ns/10ps
module brsq_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_ce,
  // Data
  input  wire logic i_d,
  output logic      o_q
);
  logic meta_reg;

  // Meta flop feeds only the second flop
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      meta_reg <= RESET_VAL;
      o_q      <= RESET_VAL;
    end
    else if (i_ce)
    begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end
endmodule // brsq_sync2

// *** bench/brsq_supply_model.sv ***
// Model of the supply detectors and the external reset pin.
// Assumes the bench sets the supply in millivolts off the clock edge.
`timescale 1ns/10ps
module brsq_supply_model #(
  parameter int TRIG_MV = 1800,
  parameter int BOR_MV  = 2800
) (
  // Commanded supply and pin
  input  wire logic [15:0] i_mv,
  input  wire logic        i_pin_low,
  // Detector levels
  output logic             o_above_trig,
  output logic             o_above_bor,
  output logic             o_ext_reset_b
);
  // Comparators follow the supply at once
  assign o_above_trig  = (i_mv > TRIG_MV);
  assign o_above_bor   = (i_mv > BOR_MV);
  // Pin is pulled up unless held low
  assign o_ext_reset_b = !i_pin_low;
endmodule // brsq_supply_model

// *** bench/testbench.sv ***
// Self-checking bench for the brownout reset sequencer.
// Assumes a short settling count and a short instruction cycle.
`timescale 1ns/10ps
module testbench;
  localparam int SC = 20;
  localparam int TC = 2;
  logic        clk = 1'b0;
  logic        rst_b, en, ls, pin_low, trig, bor, ext_b;
  logic        ce;
  logic [15:0] mv;
  logic [31:0] seed = 32'hC28F20BC;
  int          mismatches, n_compared;
  logic        core_b, load, lsp;
  logic [15:0] timer;
  logic [2:0]  status;
  logic [1:0]  mult;

  // Free-running core clock
  always #25 clk = ~clk;

  brsq_supply_model SUP (.i_mv(mv), .i_pin_low(pin_low), .o_above_trig(trig),
    .o_above_bor(bor), .o_ext_reset_b(ext_b));

  brsq_top #(.SETTLE_CYC(SC), .TC_DIV(TC)) DUT (.I_SYS_CLK(clk), .I_RST_B(rst_b),
    .I_CE(ce), .I_ABOVE_TRIG(trig), .I_ABOVE_BOR(bor), .I_BOR_ENABLE(en),
    .I_EXT_RESET_B(ext_b), .I_LOW_SPEED_SEL(ls), .O_CORE_RESET_B(core_b),
    .O_IDLE_LOAD(load), .O_IDLE_TIMER(timer), .O_STATUS(status),
    .O_CLK_MULT(mult), .O_LOW_SPEED(lsp));

  // Xorshift source
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Cycles until release must fall in a window
  task automatic measure(input int lo, input int hi);
    int n;
    n = 0;
    while (core_b !== 1'b1 && n <= hi)
    begin
      @(negedge clk);
      n++;
    end
    check("release cycle in window", 16'((n >= lo) && (n <= hi)), 16'h0001);
    if (n > hi)
      complete_run();
  endtask

  // Supply drop with an immediate reset check
  task automatic drop(input logic [15:0] v, input int len);
    mv = v;
    #1;
    check("reset on drop", 16'(core_b), 16'h0000);
    repeat (len) @(negedge clk);
  endtask

  initial
  begin
    rst_b = 1'b0; en = 1'b1; ls = 1'b0; pin_low = 1'b0; mv = 16'h0000; ce = 1'b1;
    mismatches = 0; n_compared = 0;
    repeat (2) @(negedge clk);
    check("timer at reset", timer, 16'h00FF);
    check("doubler", 16'(mult), 16'h0002);
    rst_b = 1'b1;
    mv = 16'd1200;
    repeat (10) @(negedge clk);
    check("held above one volt", 16'(core_b), 16'h0000);
    check("preset load", 16'(load), 16'h0001);
    mv = 16'd3300;
    measure(SC + 240 * TC, SC + 257 * TC + 8);
    // Steady supply, random oscillator choice
    repeat (200)
    begin
      @(negedge clk);
      check("no reset while high", 16'(core_b), 16'h0001);
      check("low speed copy", 16'(lsp), 16'(ls));
      check("status running", 16'(status), 16'(brsq_pkg::BRSQ_ST_RUN));
      ls = 1'(rnd() & 32'h1);
    end
    // Enable low freezes the low-speed output register
    @(negedge clk);
    ce = 1'b0;
    ls = !ls;
    repeat (3) @(negedge clk);
    check("frozen low speed", 16'(lsp), 16'(!ls));
    ce = 1'b1;
    @(negedge clk);
    // Shallow dips skip settling
    repeat (3)
    begin
      drop(16'd2500, 4 + (rnd() & 32'hF));
      check("preset in dip", timer, 16'h00FF);
      mv = 16'd3300;
      measure(240 * TC, 257 * TC + 8);
    end
    // Deep dip restarts settling
    drop(16'd1000, 5);
    mv = 16'd3300;
    measure(SC + 240 * TC, SC + 257 * TC + 8);
    // Settling ends before threshold
    drop(16'd1000, 5);
    mv = 16'd2000;
    repeat (SC + 10) @(negedge clk);
    check("status waiting", 16'(status), 16'(brsq_pkg::BRSQ_ST_WAIT));
    mv = 16'd3300;
    measure(240 * TC, 257 * TC + 8);
    // External pin acts like brownout
    pin_low = 1'b1;
    repeat (4) @(negedge clk);
    check("pin reset", 16'(core_b), 16'h0000);
    pin_low = 1'b0;
    measure(0, SC + 257 * TC + 8);
    // Feature off: dips ignored, pin still works
    en = 1'b0;
    repeat (4) @(negedge clk);
    repeat (3)
    begin
      mv = 16'd2500;
      repeat (2 + (rnd() & 32'h7)) @(negedge clk);
      check("no reset when off", 16'(core_b), 16'h0001);
      mv = 16'd3300;
      @(negedge clk);
    end
    pin_low = 1'b1;
    repeat (4) @(negedge clk);
    check("pin reset when off", 16'(core_b), 16'h0000);
    complete_run();
  end
endmodule // testbench
